// [core/pcec_channel_ctrl.v]
`include "pcec_defines.vh"
// ----------------------------------------------------------------
// channel enable control: registers 13h..15h and their effects
// ----------------------------------------------------------------
module pcec_channel_ctrl #(
  parameter NCH       = 4,
  parameter DISC_CYC  = `PCEC_DISC_CYC,
  parameter OVLD_CYC  = `PCEC_OVLD_CYC,
  parameter CLEAR_CYC = `PCEC_CLEAR_CYC
) (
  input  wire           i_clk,
  input  wire           i_nrst,
  input  wire           i_ce,
  // command-byte register port
  input  wire           i_wr,
  input  wire           i_rd,
  input  wire [7:0]     i_cmd,
  input  wire [7:0]     i_wdata,
  output reg  [7:0]     o_rdata,
  output wire           o_rvalid,
  // operating context
  input  wire [1:0]     i_mode,
  input  wire           i_four_pair_wired,
  input  wire           i_single_signature,
  input  wire           i_pair_cut_both,
  input  wire           i_multibit_priority_sel,
  input  wire [1:0]     i_assigned_class_hi,
  // channel status
  input  wire [NCH-1:0] i_powered,
  input  wire [NCH-1:0] i_current_below,
  input  wire [NCH-1:0] i_overload,
  input  wire [NCH-1:0] i_cooldown,
  input  wire [NCH-1:0] i_det_done,
  input  wire [NCH-1:0] i_det_valid,
  input  wire [NCH-1:0] i_cls_done,
  input  wire [NCH-1:0] i_turn_off_cmd,
  input  wire [NCH-1:0] i_restart_pb,
  input  wire [NCH-1:0] i_power_on_cmd,
  input  wire [NCH-1:0] i_alloc_ok,
  input  wire [NCH-1:0] i_det_cls_valid,
  input  wire           i_fast_shutdown_input,
  // channel actions
  output reg  [NCH-1:0] o_chan_off,
  output reg  [NCH-1:0] o_chan_on,
  output reg  [NCH-1:0] o_disc_fault_flag,
  output reg  [NCH-1:0] o_pcut_fault_flag,
  output reg  [NCH-1:0] o_det_start,
  output reg  [NCH-1:0] o_cls_start,
  output reg  [NCH-1:0] o_chan_clear,
  output reg  [7:0]     o_police_value,
  output reg  [NCH-1:0] o_disc_threshold_sel,
  output wire           o_clear_busy
);
  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  reg [7:0]     disc_en_ff;
  reg [7:0]     det_cls_en_ff;
  reg [7:0]     prio_cut_ff;
  reg [31:0]    clr_cnt_ff;
  reg [NCH-1:0] fs_q_ff;
  reg [NCH-1:0] pcut_dis_q_ff;

  reg [7:0]     nxt_det_cls_en;
  wire [NCH-1:0] dc_disc_en     = disc_en_ff[NCH-1:0];
  wire [NCH-1:0] detect_en      = det_cls_en_ff[NCH-1:0];
  wire [NCH-1:0] class_en       = det_cls_en_ff[NCH+3:4];
  wire [NCH-1:0] shutdown_prio  = prio_cut_ff[NCH+3:4];
  wire [NCH-1:0] pcut_disable   = prio_cut_ff[NCH-1:0];
  wire [NCH-1:0] disc_expire;
  wire [NCH-1:0] ovld_timeout;
  wire [NCH-1:0] fs_kill;

  wire wr_disc = i_wr && (i_cmd == `PCEC_CMD_DISC_EN);
  wire wr_dce  = i_wr && (i_cmd == `PCEC_CMD_DET_CLS_EN);
  wire wr_prio = i_wr && (i_cmd == `PCEC_CMD_PRIO_CUT);
  wire manual  = (i_mode == `PCEC_MODE_MANUAL);
  wire semi    = (i_mode == `PCEC_MODE_SEMIAUTO);
  wire autoish = semi || (i_mode == `PCEC_MODE_AUTO);

  assign o_rvalid     = i_rd;
  assign o_clear_busy = (clr_cnt_ff != 32'h0);

  // ----------------------------------------------------------------
  // per-channel timers and kill terms
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < NCH; g = g + 1) begin : g_ch
      wire pair_en = dc_disc_en[g] | dc_disc_en[g ^ 1];
      wire run = i_powered[g] &
                 ((i_four_pair_wired && i_single_signature) ? pair_en : dc_disc_en[g]);
      pcec_disc_timer #(.DISC_CYC(DISC_CYC)) u_disc (
        .i_clk    (i_clk),
        .i_nrst   (i_nrst),
        .i_ce     (i_ce),
        .i_run    (run),
        .i_below  (i_current_below[g]),
        .o_expire (disc_expire[g])
      );
      pcec_ovld_timer #(.OVLD_CYC(OVLD_CYC)) u_ovld (
        .i_clk      (i_clk),
        .i_nrst     (i_nrst),
        .i_ce       (i_ce),
        .i_overload (i_overload[g] & i_powered[g]),
        .i_restart  (pcut_disable[g] != pcut_dis_q_ff[g]), // R19
        .o_timeout  (ovld_timeout[g])
      );
      // R16 R17
      assign fs_kill[g] = i_fast_shutdown_input & !i_multibit_priority_sel
                          & shutdown_prio[g] & !fs_q_ff[g];
    end
  endgenerate

  // ----------------------------------------------------------------
  // combinational actions
  // ----------------------------------------------------------------
  integer k;
  reg [NCH-1:0] disc_off;
  reg [NCH-1:0] cut_off;
  reg [NCH-1:0] arm;
  always @* begin
    disc_off = {NCH{1'b0}};
    cut_off  = {NCH{1'b0}};
    arm      = {NCH{1'b0}};
    for (k = 0; k < NCH; k = k + 1) begin
      if (disc_expire[k]) begin
        disc_off[k] = 1'b1; // R2
        if (i_four_pair_wired && i_single_signature)
          disc_off[k ^ 1] = 1'b1; // R4
      end
      if (ovld_timeout[k] && !pcut_disable[k]) begin
        cut_off[k] = 1'b1; // R18
        if (i_four_pair_wired && i_pair_cut_both)
          cut_off[k ^ 1] = 1'b1; // R20
      end
      if (i_four_pair_wired && autoish)
        arm[k] = detect_en[k] & class_en[k] & detect_en[k ^ 1] & class_en[k ^ 1]; // R13
      else
        arm[k] = detect_en[k] | class_en[k];
    end
  end

  // ----------------------------------------------------------------
  // detect/class enable next value
  // ----------------------------------------------------------------
  always @* begin
    nxt_det_cls_en = det_cls_en_ff;
    if (wr_dce)
      nxt_det_cls_en = i_wdata;
    for (k = 0; k < NCH; k = k + 1) begin
      if (semi && i_restart_pb[k]) begin
        nxt_det_cls_en[k]     = 1'b1; // R12
        nxt_det_cls_en[k + 4] = 1'b1;
      end
      if (manual && i_det_done[k])
        nxt_det_cls_en[k] = 1'b0; // R9
      if (manual && i_cls_done[k])
        nxt_det_cls_en[k + 4] = 1'b0; // R9
      if (i_turn_off_cmd[k] || fs_kill[k] || i_mode == `PCEC_MODE_OFF) begin
        nxt_det_cls_en[k]     = 1'b0; // R10 R22
        nxt_det_cls_en[k + 4] = 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // register and sequencing state
  // ----------------------------------------------------------------
  always @(posedge i_clk) begin
    if (!i_nrst) begin
      disc_en_ff           <= `PCEC_RST_DISC_EN; // R1
      det_cls_en_ff        <= `PCEC_RST_DET_CLS_EN; // R7
      prio_cut_ff          <= `PCEC_RST_PRIO_CUT; // R15
      clr_cnt_ff           <= 32'h0;
      fs_q_ff              <= {NCH{1'b0}};
      pcut_dis_q_ff        <= {NCH{1'b0}};
      o_chan_off           <= {NCH{1'b0}};
      o_chan_on            <= {NCH{1'b0}};
      o_disc_fault_flag    <= {NCH{1'b0}};
      o_pcut_fault_flag    <= {NCH{1'b0}};
      o_det_start          <= {NCH{1'b0}};
      o_cls_start          <= {NCH{1'b0}};
      o_chan_clear         <= {NCH{1'b0}};
      o_police_value       <= 8'h00;
      o_disc_threshold_sel <= {NCH{1'b0}};
      o_rdata              <= 8'h00;
    end else if (i_ce) begin
      if (wr_disc)
        disc_en_ff <= i_wdata; // R1
      if (wr_prio)
        prio_cut_ff <= i_wdata; // R15
      det_cls_en_ff <= nxt_det_cls_en;
      fs_q_ff       <= {NCH{i_fast_shutdown_input}} & shutdown_prio;
      pcut_dis_q_ff <= pcut_disable;
      o_chan_off    <= disc_off | cut_off | fs_kill;
      // R5: single channel of dual-signature port repowered on command
      o_chan_on     <= i_power_on_cmd & ~i_powered & i_alloc_ok & i_det_cls_valid
                       & {NCH{i_mode != `PCEC_MODE_OFF}};
      // R2 R18: set wins; fast shutdown clears the channel's flags
      o_disc_fault_flag <= (o_disc_fault_flag & ~fs_kill) | disc_off;
      o_pcut_fault_flag <= (o_pcut_fault_flag & ~fs_kill) | ovld_timeout;
      // R8: start held off in cooldown, resumes when it ends if still armed
      // R11: semiauto cycles while unpowered; class only after valid detect
      o_det_start <= arm & ~i_cooldown & ~i_powered & detect_en
                     & {NCH{i_mode != `PCEC_MODE_OFF}};
      o_cls_start <= arm & ~i_cooldown & ~i_powered & class_en
                     & (manual ? {NCH{1'b1}} : i_det_valid)
                     & {NCH{i_mode != `PCEC_MODE_OFF}};
      // R6: threshold select chosen at turn-on
      for (k = 0; k < NCH; k = k + 1) begin
        if (o_chan_on[k])
          o_disc_threshold_sel[k] <= i_four_pair_wired & (i_assigned_class_hi != 2'h0);
        else if (fs_kill[k])
          o_disc_threshold_sel[k] <= 1'b0;
      end
      // R21 R22: cleared state held off; cooldown inputs untouched
      o_chan_clear <= (o_chan_clear & {NCH{clr_cnt_ff > 32'h1}}) | fs_kill;
      if (|fs_kill) begin
        clr_cnt_ff     <= CLEAR_CYC;
        o_police_value <= `PCEC_POLICE_CLEARED; // R22
      end else if (clr_cnt_ff != 32'h0) begin
        clr_cnt_ff <= clr_cnt_ff - 32'h1;
      end
      if (i_rd) begin
        case (i_cmd)
          `PCEC_CMD_DISC_EN:    o_rdata <= disc_en_ff;
          `PCEC_CMD_DET_CLS_EN: o_rdata <= det_cls_en_ff;
          `PCEC_CMD_PRIO_CUT:   o_rdata <= prio_cut_ff;
          default:              o_rdata <= 8'h00;
        endcase
      end
    end
  end
endmodule // pcec_channel_ctrl

// [core/pcec_defines.vh]
`ifndef PCEC_DEFINES_VH
`define PCEC_DEFINES_VH
// Operation
// (R1) disconnect enable reg 13h, low nibble resets one
// (R2) low current runs timer; timeout kills channel
// (R3) 3 ms above threshold resets timer
// (R4) 4-pair single signature: both channels off
// (R5) repower single channel on power-on command
// (R6) threshold select set at turn-on
// (R7) detect/class enable reg 14h resets zero
// (R8) enables wait out fault cooldown
// (R9) manual mode: one cycle, bit self-clears
// (R10) turn-off command clears detect/class enables
// (R11) semiauto repeats; classify after valid detect
// (R12) restart push-button sets enables in semiauto
// (R13) 4-pair port needs all four bits; code checks this in auto/semiauto only
// (R14) host resets port before manual enables
// (R15) priority/cut-disable reg 15h resets zero
// (R16) fast shutdown kills priority-set channels
// (R17) host clears priority bits in multibit mode
// (R18) cut-disable keeps power, still flags fault
// (R19) cut-disable change restarts overload timer
// (R20) pair-cut-both kills both channels on overload
// (R21) fast shutdown keeps cooldown timers running
// (R22) fast shutdown clears channel state, policing ff

// ----------------------------------------------------------------
// register command codes and resets
// ----------------------------------------------------------------
`define PCEC_CMD_DISC_EN      8'h13
`define PCEC_CMD_DET_CLS_EN   8'h14
`define PCEC_CMD_PRIO_CUT     8'h15
`define PCEC_RST_DISC_EN      8'h0f
`define PCEC_RST_DET_CLS_EN   8'h00
`define PCEC_RST_PRIO_CUT     8'h00
`define PCEC_POLICE_CLEARED   8'hff

// ----------------------------------------------------------------
// operating modes
// ----------------------------------------------------------------
`define PCEC_MODE_OFF         2'h0
`define PCEC_MODE_MANUAL      2'h1
`define PCEC_MODE_SEMIAUTO    2'h2
`define PCEC_MODE_AUTO        2'h3

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define PCEC_CLK_HZ           10000000
`define PCEC_ABOVE_MS         3
`define PCEC_ABOVE_CYC        ((`PCEC_ABOVE_MS * `PCEC_CLK_HZ) / 1000)
`define PCEC_CLEAR_MS         5
`define PCEC_CLEAR_CYC        ((`PCEC_CLEAR_MS * `PCEC_CLK_HZ) / 1000)
`define PCEC_DISC_CYC         4000000
`define PCEC_OVLD_CYC         600000
`endif

// [core/pcec_disc_timer.v]
`include "pcec_defines.vh"
// ----------------------------------------------------------------
// per-channel disconnect timer
// ----------------------------------------------------------------
module pcec_disc_timer #(
  parameter DISC_CYC  = `PCEC_DISC_CYC,
  parameter ABOVE_CYC = `PCEC_ABOVE_CYC
) (
  input  wire i_clk,
  input  wire i_nrst,
  input  wire i_ce,
  input  wire i_run,
  input  wire i_below,
  output wire o_expire
);
  reg [31:0] disc_timer_ff;
  reg [31:0] above_ff;

  assign o_expire = (disc_timer_ff >= DISC_CYC);

  always @(posedge i_clk) begin
    if (!i_nrst) begin
      disc_timer_ff <= 32'h0;
      above_ff      <= 32'h0;
    end else if (i_ce) begin
      if (!i_run) begin
        disc_timer_ff <= 32'h0;
        above_ff      <= 32'h0;
      end else if (i_below) begin
        above_ff <= 32'h0;
        if (!o_expire)
          disc_timer_ff <= disc_timer_ff + 32'h1; // R2
      end else begin
        if (above_ff >= ABOVE_CYC - 1) begin
          disc_timer_ff <= 32'h0; // R3
        end else begin
          above_ff <= above_ff + 32'h1;
        end
      end
    end
  end
endmodule // pcec_disc_timer

// [core/pcec_ovld_timer.v]
`include "pcec_defines.vh"
// ----------------------------------------------------------------
// per-channel overload timer, restarted on cut-disable change
// ----------------------------------------------------------------
module pcec_ovld_timer #(
  parameter OVLD_CYC = `PCEC_OVLD_CYC
) (
  input  wire i_clk,
  input  wire i_nrst,
  input  wire i_ce,
  input  wire i_overload,
  input  wire i_restart,
  output wire o_timeout
);
  reg [31:0] cnt_ff;

  assign o_timeout = (cnt_ff >= OVLD_CYC);

  always @(posedge i_clk) begin
    if (!i_nrst) begin
      cnt_ff <= 32'h0;
    end else if (i_ce) begin
      if (i_restart || !i_overload)
        cnt_ff <= 32'h0; // R19
      else if (!o_timeout)
        cnt_ff <= cnt_ff + 32'h1;
    end
  end
endmodule // pcec_ovld_timer

// [tb/pcec_props.sv]
// ----------------------------------------
// port checks for the channel enable block
// ----------------------------------------
module pcec_props #(parameter NCH = 4, parameter CLEAR_CYC = 50000) (
  input logic           i_clk,
  input logic           i_nrst,
  input logic           i_ce,
  input logic           i_wr,
  input logic           i_rd,
  input logic [7:0]     i_cmd,
  input logic [7:0]     i_wdata,
  input logic [7:0]     o_rdata,
  input logic           o_rvalid,
  input logic           i_multibit_priority_sel,
  input logic [NCH-1:0] i_powered,
  input logic [NCH-1:0] i_cooldown,
  input logic           i_fast_shutdown_input,
  input logic [NCH-1:0] o_chan_off,
  input logic [NCH-1:0] o_disc_fault_flag,
  input logic [NCH-1:0] o_pcut_fault_flag,
  input logic [NCH-1:0] o_det_start,
  input logic [NCH-1:0] o_chan_clear,
  input logic [7:0]     o_police_value,
  input logic           o_clear_busy
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_nrst);
  logic [3:0] prio_ff;
  logic [3:0] cut_ff;
  logic [31:0] quiet_ff;
  // cycles since the shutdown input was last high, saturating
  always @(posedge i_clk) begin
    if (!i_nrst)
      quiet_ff <= 32'h0;
    else if (i_ce && i_fast_shutdown_input)
      quiet_ff <= 32'h0;
    else if (i_ce && quiet_ff <= CLEAR_CYC)
      quiet_ff <= quiet_ff + 32'h1;
  end
  // shadow of the priority / cut-disable register
  always @(posedge i_clk) begin
    if (!i_nrst) begin
      prio_ff <= 4'h0;
      cut_ff  <= 4'h0;
    end else if (i_ce && i_wr && i_cmd == 8'h15) begin
      prio_ff <= i_wdata[7:4];
      cut_ff  <= i_wdata[3:0];
    end
  end
  property p_unmapped;
    i_ce && i_rd && !i_wr && (i_cmd < 8'h13 || i_cmd > 8'h15) |=> o_rdata == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_rvalid;
    i_rd |-> o_rvalid;
  endproperty
  a_rvalid: assert property (p_rvalid) else $error("read not acknowledged");
  property p_fs_off;
    $rose(i_fast_shutdown_input) && !i_multibit_priority_sel && prio_ff[0] |-> ##[1:3] o_chan_off[0];
  endproperty
  a_fs_off: assert property (p_fs_off) else $error("fast shutdown left channel on");
  property p_police;
    o_chan_clear != 0 |-> ##[0:2] o_police_value == 8'hff;
  endproperty
  a_police: assert property (p_police) else $error("policing not set on clear");
  property p_clear_len;
    quiet_ff > CLEAR_CYC |-> !o_clear_busy;
  endproperty
  a_clear_len: assert property (p_clear_len) else $error("clear ran too long");
  property p_disc_off;
    $rose(o_disc_fault_flag[1]) |-> o_chan_off[1];
  endproperty
  a_disc_off: assert property (p_disc_off) else $error("disconnect flag without turn off");
  property p_det_unpwr;
    o_det_start[0] |-> !$past(i_powered[0]);
  endproperty
  a_det_unpwr: assert property (p_det_unpwr) else $error("detection on powered channel");
  property p_cool;
    o_det_start[0] |-> !$past(i_cooldown[0]);
  endproperty
  a_cool: assert property (p_cool) else $error("detection during cooldown");
  property p_cut;
    $rose(o_pcut_fault_flag[0]) && cut_ff[0] && !$rose(o_disc_fault_flag[0])
      && !i_fast_shutdown_input |-> !o_chan_off[0];
  endproperty
  a_cut: assert property (p_cut) else $error("cut-disabled channel turned off");
endmodule // pcec_props

bind pcec_channel_ctrl pcec_props #(.NCH(NCH), .CLEAR_CYC(CLEAR_CYC)) pcec_props_inst (
  .i_clk, .i_nrst, .i_ce, .i_wr, .i_rd, .i_cmd, .i_wdata, .o_rdata, .o_rvalid,
  .i_multibit_priority_sel, .i_powered, .i_cooldown, .i_fast_shutdown_input,
  .o_chan_off, .o_disc_fault_flag, .o_pcut_fault_flag, .o_det_start,
  .o_chan_clear, .o_police_value, .o_clear_busy
);

// [tb/pcec_host_model.sv]
// ----------------------------------------
// host issuing command-byte transfers
// ----------------------------------------
module pcec_host_model (
  input  logic       i_clk,
  input  logic       i_mbit,
  input  logic [7:0] i_rdata,
  output logic       o_wr,
  output logic       o_rd,
  output logic [7:0] o_cmd,
  output logic [7:0] o_wdata
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    o_wr = 1'b0;
    o_rd = 1'b0;
    o_cmd = 8'h00;
    o_wdata = 8'h00;
  end
  task automatic wr(input logic [7:0] c, input logic [7:0] d);
    @(posedge i_clk);
    o_wr <= 1'b1;
    o_cmd <= c;
    o_wdata <= (c == 8'h15 && i_mbit) ? {4'h0, d[3:0]} : d;
    @(posedge i_clk);
    o_wr <= 1'b0;
    o_cmd <= ~c;
    o_wdata <= ~d;
  endtask
  task automatic rd(input logic [7:0] c, output logic [7:0] d);
    @(posedge i_clk);
    o_rd <= 1'b1;
    o_cmd <= c;
    @(posedge i_clk);
    o_rd <= 1'b0;
    o_cmd <= ~c;
    @(posedge i_clk);
    d = i_rdata;
  endtask
endmodule // pcec_host_model

// [tb/pse_channel_enable_control_bench.sv]
module pse_channel_enable_control_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic       clk = 1'b0, nrst = 1'b0, fs = 1'b0, mbit = 1'b0;
  logic       fpw = 1'b0, ssig = 1'b0, pcb = 1'b0;
  logic [1:0] mode = 2'h0, cls_hi = 2'h0;
  logic [3:0] pwr = 4'h0, below = 4'h0, ovl = 4'h0, cool = 4'h0, ddone = 4'h0, dval = 4'h0;
  logic [3:0] cdone = 4'h0, toff = 4'h0, rpb = 4'h0, pon = 4'h0, aok = 4'h0, dcv = 4'h0;
  logic [3:0] off_o, dflag, pflag, dst, clr, seen, on_o, cst, thr;
  logic [7:0] rdata, pol, cmd, wdata, rb, e;
  logic       wr, rd, busy;
  int         err_total = 0, num_checks = 0, cyc = 0;
  integer     seed = 32'h2621d7cb;
  always #50 clk = ~clk;
  pcec_host_model pcec_host_model_inst (.i_clk(clk), .i_mbit(mbit), .i_rdata(rdata),
    .o_wr(wr), .o_rd(rd), .o_cmd(cmd), .o_wdata(wdata));
  pcec_channel_ctrl #(.DISC_CYC(20), .OVLD_CYC(20), .CLEAR_CYC(20)) pcec_channel_ctrl_inst (
    .i_clk(clk), .i_nrst(nrst), .i_ce(1'b1), .i_wr(wr), .i_rd(rd), .i_cmd(cmd),
    .i_wdata(wdata), .o_rdata(rdata), .o_rvalid(), .i_mode(mode), .i_four_pair_wired(fpw),
    .i_single_signature(ssig), .i_pair_cut_both(pcb), .i_multibit_priority_sel(mbit),
    .i_assigned_class_hi(cls_hi), .i_powered(pwr), .i_current_below(below),
    .i_overload(ovl), .i_cooldown(cool), .i_det_done(ddone), .i_det_valid(dval),
    .i_cls_done(cdone), .i_turn_off_cmd(toff), .i_restart_pb(rpb), .i_power_on_cmd(pon),
    .i_alloc_ok(aok), .i_det_cls_valid(dcv), .i_fast_shutdown_input(fs),
    .o_chan_off(off_o), .o_chan_on(on_o), .o_disc_fault_flag(dflag), .o_pcut_fault_flag(pflag),
    .o_det_start(dst), .o_cls_start(cst), .o_chan_clear(clr), .o_police_value(pol),
    .o_disc_threshold_sel(thr), .o_clear_busy(busy));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rc(input logic [7:0] c, input logic [7:0] x);
    pcec_host_model_inst.rd(c, rb);
    chk(rb, x);
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      finish_test;
    end
  end
  initial begin
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    rc(8'h13, 8'h0f);
    rc(8'h14, 8'h00);
    rc(8'h15, 8'h00);
    pcec_host_model_inst.wr(8'h16, 8'hff);
    rc(8'h16, 8'h00);
    for (int i = 0; i < 4; i++) begin
      e = $random(seed);
      pcec_host_model_inst.wr(8'h13, e);
      rc(8'h13, e);
      e = $random(seed);
      pcec_host_model_inst.wr(8'h15, e);
      rc(8'h15, e);
    end
    $display("reset and access test done");
    // enables left clear and channel idle before manual discovery, as after a port reset
    mode <= 2'h1;
    pcec_host_model_inst.wr(8'h14, 8'h11);
    repeat (20) if (!dst[0]) @(posedge clk);
    chk({7'h0, dst[0]}, 8'h01);
    chk({7'h0, cst[0]}, 8'h01);
    ddone <= 4'h1;
    @(posedge clk) ddone <= 4'h0;
    repeat (5) @(posedge clk);
    cdone <= 4'h1;
    @(posedge clk) cdone <= 4'h0;
    repeat (5) @(posedge clk);
    rc(8'h14, 8'h00);
    $display("manual mode test done");
    mode <= 2'h3;
    pwr <= 4'hf;
    pcec_host_model_inst.wr(8'h14, 8'hff);
    toff <= 4'h4;
    @(posedge clk) toff <= 4'h0;
    rc(8'h14, 8'hbb);
    mode <= 2'h2;
    rpb <= 4'h4;
    @(posedge clk) rpb <= 4'h0;
    rc(8'h14, 8'hff);
    $display("turn-off test done");
    pcec_host_model_inst.wr(8'h13, 8'h02);
    pcec_host_model_inst.wr(8'h15, 8'h01);
    below <= 4'h3;
    ovl <= 4'h1;
    repeat (100) if (!dflag[1] || !pflag[0]) @(posedge clk);
    chk({4'h0, dflag}, 8'h02);
    chk({7'h0, pflag[0]}, 8'h01);
    below <= 4'h0;
    ovl <= 4'h0;
    $display("disconnect and cut test done");
    pcec_host_model_inst.wr(8'h15, 8'h50);
    pcec_host_model_inst.wr(8'h14, 8'hff);
    fs <= 1'b1;
    seen = 4'h0;
    for (int i = 0; i < 10; i++) begin
      @(posedge clk);
      seen |= off_o;
    end
    chk({4'h0, seen & 4'hd}, 8'h05);
    chk({7'h0, busy}, 8'h01);
    repeat (60) @(posedge clk);
    chk(pol, 8'hff);
    chk({pflag, dflag}, 8'h02);
    rc(8'h14, 8'haa);
    pwr <= 4'he;
    fpw <= 1'b1;
    cls_hi <= 2'h1;
    aok <= 4'hf;
    dcv <= 4'hf;
    pon <= 4'h1;
    @(posedge clk) pon <= 4'h0;
    @(negedge clk) chk({4'h0, on_o}, 8'h01);
    @(negedge clk) chk({4'h0, thr}, 8'h01);
    @(posedge clk) fs <= 1'b0;
    repeat (25) @(posedge clk);
    @(negedge clk) chk({7'h0, busy}, 8'h00);
    $display("fast shutdown test done");
    repeat (300) begin
      @(posedge clk);
      {fpw, ssig, pcb, mbit, cls_hi, below, ovl, cool, dval, dcv, aok, rpb, pon, toff,
       ddone, cdone, pwr, mode, fs} <= 57'({$random(seed), $random(seed)});
    end
    $display("random context test done");
    finish_test;
  end
endmodule // pse_channel_enable_control_bench
